// [verilog/sat_arith_consts.svh]
// Function
// [RULE1] A division by a zero divisor sets the instruction error flag.
// [RULE2] Zero divisor: skip, keep destinations, drive instruction output low.
// [RULE3] Error flag stays set until the program clears it.
// [RULE4] Division stores signed quotient low, remainder in the next word.
// [RULE5] Destination is the third index register: keep quotient, drop remainder.
// [RULE6] -32768 divided by -1 gives quotient -32768, remainder 0.
// [RULE7] Double-word add sums two signed 32-bit word pairs into destination pair.
// [RULE8] Double-word subtract takes second pair from first into destination pair.
// [RULE9] Higher word of a pair holds bits 31..16, lower word bits 15..0.
// [RULE10] Double-word result above the positive limit stores 2147483647.
// [RULE11] Double-word result below the negative limit stores -2147483648.
// [RULE12] Double-word output high only on saturation, low when off or in range.
// [RULE13] Add-with-carry sums both words plus carry flag into destination.
// [RULE14] Add-with-carry sets carry on carry out, clears it otherwise.
// [RULE15] Add-with-carry output high when signed result leaves 16-bit range.
// [RULE16] Add-with-carry with input off: no execution, output low, carry kept.
// [RULE17] Program clears carry, adds low words, then adds high words.
// [RULE18] Carry is unsigned carry out of bit 15 including incoming carry.
// [RULE19] Carry and error flags hold between instructions unless updated.
`ifndef SAT_ARITH_CONSTS_SVH
`define SAT_ARITH_CONSTS_SVH

`define OFS_OPA      6'h00
`define OFS_OPB      6'h04
`define OFS_CMD      6'h08
`define OFS_RES      6'h0C
`define OFS_FLAGS    6'h10
`define OFS_IRQ_STAT 6'h14
`define OFS_IRQ_EN   6'h18
`define OFS_IRQ_CLR  6'h1C

`define CMD_OP_MSB   2
`define CMD_IN_BIT   3
`define CMD_K_BIT    4
`define CMD_W        5

`define OPC_DIV      3'h1
`define OPC_DADD     3'h2
`define OPC_DSUB     3'h3
`define OPC_ADDC     3'h4

`define FLG_CARRY    0
`define FLG_ERR      1
`define FLG_OUT      2

`define EV_DIVZERO   0
`define EV_SAT       1
`define EV_CARRY     2
`define EV_W         3

`define SAT_MAX      32'h7FFFFFFF
`define SAT_MIN      32'h80000000
`define S16_MIN      16'h8000
`define S16_NEG1     16'hFFFF
`define RST_WORD     32'h00000000

`endif

// [verilog/sat_arith_pkg.sv]
`default_nettype none
`include "sat_arith_consts.svh"

package sat_arith_pkg;

   typedef logic [31:0] bus_word_t;

   typedef struct packed {
      bus_word_t             opa;
      bus_word_t             opb;
      bus_word_t             res;
      logic [`CMD_W-1:0]     cmd;
      logic                  carry;
      logic                  err;
      logic                  outb;
      logic [`EV_W-1:0]      irq_st;
      logic [`EV_W-1:0]      irq_en;
      logic                  irq;
      logic                  waitreq;
      bus_word_t             rdata;
   } state_t;

endpackage
`default_nettype wire

// [verilog/saturating_arith_unit.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sat_arith_consts.svh"

module saturating_arith_unit #(
   parameter int WORD_W = 16
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [5:0]            address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire sat_arith_pkg::bus_word_t writedata,
   input  wire logic [3:0]            byteenable,
   output var  sat_arith_pkg::bus_word_t readdata,
   output logic                       waitrequest,
   output logic                       irq,
   output logic                       instruction_out,
   output logic                       carry_flag_device_bit,
   output logic                       error_flag_device_bit
);
   import sat_arith_pkg::*;

   localparam int DW = 2 * WORD_W;

   // ***************************************************************
   // State and bus handshake
   // ***************************************************************

   state_t s_q;
   state_t s_d;

   logic           take_wr;
   logic           exec;
   logic [2:0]     op;
   logic           in_on;
   logic           dest_k;

   // A request is taken on the edge where waitrequest is seen low.
   assign take_wr = write && !s_q.waitreq;
   assign exec    = take_wr && (address == `OFS_CMD) && byteenable[0];
   assign op      = writedata[`CMD_OP_MSB:0];
   assign in_on   = writedata[`CMD_IN_BIT];
   assign dest_k  = writedata[`CMD_K_BIT];

   // ***************************************************************
   // Arithmetic
   // ***************************************************************

   logic signed [WORD_W-1:0] div_a;
   logic signed [WORD_W-1:0] div_b;
   logic signed [WORD_W-1:0] quo;
   logic signed [WORD_W-1:0] rem;
   logic                     div_zero;
   logic                     div_special;
   logic signed [DW:0]       dadd_x;
   logic signed [DW:0]       dsub_x;
   logic [WORD_W:0]          addc_u;
   logic [WORD_W:0]          addc_s;
   logic                     addc_ovf;

   assign div_a       = s_q.opa[WORD_W-1:0];
   assign div_b       = s_q.opb[WORD_W-1:0];
   assign div_zero    = (div_b == '0);
   assign div_special = (div_a == `S16_MIN) && (div_b == `S16_NEG1);

   // The special pair is steered away from the divider, whose result
   // for it is not representable; the divide by zero is also masked.
   always_comb begin
      quo = '0;
      rem = '0;
      if (div_special) begin
         quo = `S16_MIN; // RULE6
         rem = '0;
      end else if (!div_zero) begin
         quo = div_a / div_b;
         rem = div_a % div_b;
      end
   end

   // Sign extension by one bit catches every 32-bit overflow.
   assign dadd_x = {s_q.opa[DW-1], s_q.opa} + {s_q.opb[DW-1], s_q.opb}; // RULE7
   assign dsub_x = {s_q.opa[DW-1], s_q.opa} - {s_q.opb[DW-1], s_q.opb}; // RULE8

   assign addc_u = {1'b0, s_q.opa[WORD_W-1:0]} + {1'b0, s_q.opb[WORD_W-1:0]}
                 + {{WORD_W{1'b0}}, s_q.carry}; // RULE13 RULE18
   assign addc_s = {s_q.opa[WORD_W-1], s_q.opa[WORD_W-1:0]}
                 + {s_q.opb[WORD_W-1], s_q.opb[WORD_W-1:0]}
                 + {{WORD_W{1'b0}}, s_q.carry};
   assign addc_ovf = addc_s[WORD_W] != addc_s[WORD_W-1]; // RULE15

   function automatic bus_word_t sat32(input logic signed [DW:0] x);
      if (x[DW] != x[DW-1])
         sat32 = x[DW] ? `SAT_MIN : `SAT_MAX; // RULE10 RULE11
      else
         sat32 = x[DW-1:0];
   endfunction

   function automatic bus_word_t merge(input bus_word_t old,
                                       input bus_word_t wd,
                                       input logic [3:0] be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            merge[i*8 +: 8] = wd[i*8 +: 8];
      end
   endfunction

   function automatic bus_word_t rd_mux(input state_t s,
                                        input logic [5:0] a);
      rd_mux = `RST_WORD;
      case (a)
         `OFS_OPA:      rd_mux = s.opa;
         `OFS_OPB:      rd_mux = s.opb;
         `OFS_CMD:      rd_mux = DW'(s.cmd);
         `OFS_RES:      rd_mux = s.res;
         `OFS_FLAGS:    rd_mux = DW'({s.outb, s.err, s.carry});
         `OFS_IRQ_STAT: rd_mux = DW'(s.irq_st);
         `OFS_IRQ_EN:   rd_mux = DW'(s.irq_en);
         default:       rd_mux = `RST_WORD;
      endcase
   endfunction

   // ***************************************************************
   // Next state
   // ***************************************************************

   always_comb begin
      logic [`EV_W-1:0] ev;
      logic [`EV_W-1:0] clr;
      ev  = '0;
      clr = '0;
      s_d = s_q;
      s_d.waitreq = !((read || write) && s_q.waitreq);
      if (read && s_q.waitreq)
         s_d.rdata = rd_mux(s_q, address);
      if (take_wr) begin
         case (address)
            `OFS_OPA: s_d.opa = merge(s_q.opa, writedata, byteenable);
            `OFS_OPB: s_d.opb = merge(s_q.opb, writedata, byteenable);
            `OFS_FLAGS: begin
               if (byteenable[0]) begin
                  // The carry clear instruction and the error reset.
                  if (writedata[`FLG_CARRY])
                     s_d.carry = 1'b0;
                  if (writedata[`FLG_ERR])
                     s_d.err = 1'b0; // RULE3
               end
            end
            `OFS_IRQ_EN: begin
               if (byteenable[0])
                  s_d.irq_en = writedata[`EV_W-1:0];
            end
            `OFS_IRQ_CLR: begin
               if (byteenable[0])
                  clr = writedata[`EV_W-1:0];
            end
            default: ;
         endcase
      end
      if (exec) begin
         s_d.cmd  = writedata[`CMD_W-1:0];
         s_d.outb = 1'b0; // RULE12 RULE16
         if (in_on) begin
            case (op)
               `OPC_DIV: begin
                  if (div_zero) begin // RULE2
                     s_d.err = 1'b1; // RULE1
                     ev[`EV_DIVZERO] = 1'b1;
                  end else begin
                     s_d.res[WORD_W-1:0] = quo; // RULE4
                     if (!dest_k)
                        s_d.res[DW-1:WORD_W] = rem; // RULE5
                     s_d.outb = 1'b1;
                  end
               end
               `OPC_DADD: begin
                  s_d.res  = sat32(dadd_x); // RULE9
                  s_d.outb = dadd_x[DW] != dadd_x[DW-1]; // RULE12
                  ev[`EV_SAT] = s_d.outb;
               end
               `OPC_DSUB: begin
                  s_d.res  = sat32(dsub_x);
                  s_d.outb = dsub_x[DW] != dsub_x[DW-1];
                  ev[`EV_SAT] = s_d.outb;
               end
               `OPC_ADDC: begin
                  s_d.res[WORD_W-1:0] = addc_u[WORD_W-1:0];
                  s_d.carry = addc_u[WORD_W]; // RULE14
                  s_d.outb  = addc_ovf;
                  ev[`EV_SAT]   = addc_ovf;
                  ev[`EV_CARRY] = addc_u[WORD_W];
               end
               default: ;
            endcase
         end
      end
      // An event in the cycle of its clear keeps the bit set.
      s_d.irq_st = (s_q.irq_st & ~clr) | ev;
      s_d.irq    = |(s_d.irq_st & s_d.irq_en);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q         <= '0;
         s_q.waitreq <= 1'b1;
      end else begin
         s_q <= s_d; // RULE19
      end
   end

   assign readdata              = s_q.rdata;
   assign waitrequest           = s_q.waitreq;
   assign irq                   = s_q.irq;
   assign instruction_out       = s_q.outb;
   assign carry_flag_device_bit = s_q.carry;
   assign error_flag_device_bit = s_q.err;

   // ***************************************************************
   // Assertions
   // ***************************************************************

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic clr_err_wr;
   logic clr_cf_wr;
   assign clr_err_wr = take_wr && address == `OFS_FLAGS
                     && byteenable[0] && writedata[`FLG_ERR];
   assign clr_cf_wr  = take_wr && address == `OFS_FLAGS
                     && byteenable[0] && writedata[`FLG_CARRY];

   property p_div_zero_err;
      exec && in_on && op == `OPC_DIV && div_zero |=> error_flag_device_bit;
   endproperty
   a_div_zero_err: assert property (p_div_zero_err) // RULE1
      else $error("Zero divisor did not set the error flag.");

   property p_div_zero_skip;
      exec && in_on && op == `OPC_DIV && div_zero
         |=> !instruction_out && $stable(s_q.res);
   endproperty
   a_div_zero_skip: assert property (p_div_zero_skip) // RULE2
      else $error("Zero divisor changed the result or raised the output.");

   property p_err_sticky;
      error_flag_device_bit && !clr_err_wr |=> error_flag_device_bit;
   endproperty
   a_err_sticky: assert property (p_err_sticky) // RULE3
      else $error("Error flag dropped without a program reset.");

   property p_div_result;
      exec && in_on && op == `OPC_DIV && !div_zero && !div_special && !dest_k
         |=> instruction_out
          && $signed(s_q.res[WORD_W-1:0]) * $past(div_b)
             + $signed(s_q.res[DW-1:WORD_W]) == $past(div_a);
   endproperty
   a_div_result: assert property (p_div_result) // RULE4
      else $error("Quotient and remainder do not rebuild the dividend.");

   property p_div_k;
      exec && in_on && op == `OPC_DIV && !div_zero && dest_k
         |=> s_q.res[DW-1:WORD_W] == $past(s_q.res[DW-1:WORD_W]);
   endproperty
   a_div_k: assert property (p_div_k) // RULE5
      else $error("Remainder written for an index destination.");

   property p_div_special;
      exec && in_on && op == `OPC_DIV && div_special && !dest_k
         |=> s_q.res == {{WORD_W{1'b0}}, `S16_MIN};
   endproperty
   a_div_special: assert property (p_div_special) // RULE6
      else $error("Most negative by minus one gave the wrong result.");

   property p_dadd;
      exec && in_on && op == `OPC_DADD
         |=> !instruction_out |-> s_q.res == $past(s_q.opa) + $past(s_q.opb);
   endproperty
   a_dadd: assert property (p_dadd) // RULE7 RULE9
      else $error("Double-word sum wrong without saturation.");

   property p_dsub;
      exec && in_on && op == `OPC_DSUB
         |=> !instruction_out |-> s_q.res == $past(s_q.opa) - $past(s_q.opb);
   endproperty
   a_dsub: assert property (p_dsub) // RULE8
      else $error("Double-word difference wrong without saturation.");

   property p_sat;
      exec && in_on && (op == `OPC_DADD || op == `OPC_DSUB)
         |=> instruction_out |->
             (s_q.res == `SAT_MAX || s_q.res == `SAT_MIN);
   endproperty
   a_sat: assert property (p_sat) // RULE10 RULE11 RULE12
      else $error("Saturated double-word result is not a limit value.");

   property p_addc;
      exec && in_on && op == `OPC_ADDC
         |=> {carry_flag_device_bit, s_q.res[WORD_W-1:0]}
             == $past(s_q.opa[WORD_W-1:0]) + $past(s_q.opb[WORD_W-1:0])
                + $past(s_q.carry)
             && instruction_out == $past(addc_ovf);
   endproperty
   a_addc: assert property (p_addc) // RULE13 RULE14 RULE15 RULE18
      else $error("Add with carry gave a wrong sum, carry or output.");

   property p_off;
      exec && !in_on |=> !instruction_out && $stable(carry_flag_device_bit)
                         && $stable(s_q.res);
   endproperty
   a_off: assert property (p_off) // RULE12 RULE16
      else $error("Instruction acted while its input was off.");

   property p_carry_hold;
      !(exec && in_on && op == `OPC_ADDC) && !clr_cf_wr
         |=> $stable(carry_flag_device_bit);
   endproperty
   a_carry_hold: assert property (p_carry_hold) // RULE19
      else $error("Carry flag changed without an instruction.");

   property p_err_clear;
      clr_err_wr |=> !error_flag_device_bit;
   endproperty
   a_err_clear: assert property (p_err_clear) // RULE3
      else $error("Error flag survived a program reset.");

   property p_carry_clear;
      clr_cf_wr |=> !carry_flag_device_bit;
   endproperty
   a_carry_clear: assert property (p_carry_clear) // RULE19
      else $error("Carry clear instruction left the carry flag set.");

   property p_div_zero_event;
      exec && in_on && op == `OPC_DIV && div_zero |=> s_q.irq_st[`EV_DIVZERO];
   endproperty
   a_div_zero_event: assert property (p_div_zero_event) // RULE1
      else $error("Zero divisor did not record its status bit.");

   // One wait state per access keeps the bus timing fixed for software.
   property p_wait_one;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("Bus answer did not take exactly one wait state.");

   c_div_zero: cover property (exec && in_on && op == `OPC_DIV && div_zero);
   c_dadd_sat: cover property (exec && in_on && op == `OPC_DADD ##1 instruction_out);
   c_addc_chain: cover property (exec && in_on && op == `OPC_ADDC
                                 ##1 carry_flag_device_bit ##[1:20] exec);
   c_irq: cover property (irq);
   c_div_k: cover property (exec && in_on && op == `OPC_DIV && dest_k);

endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "sat_arith_consts.svh"

module testbench;
   import sat_arith_pkg::*;

   // ************************************************************
   // Signals
   // ************************************************************
   logic                 clk;
   logic                 rst_n;
   logic [5:0]           address;
   logic                 read;
   logic                 write;
   bus_word_t            writedata;
   logic [3:0]           byteenable;
   bus_word_t            readdata;
   logic                 waitrequest;
   logic                 irq;
   logic                 instruction_out;
   logic                 carry_flag_device_bit;
   logic                 error_flag_device_bit;
   int                   n_errors;
   int                   comparisons;
   bus_word_t            rd;
   localparam bus_word_t lo = 32'h0000FFFF;
   localparam bus_word_t al = 32'hFFFFFFFF;
   localparam bus_word_t k  = 32'h00000010;
   localparam bus_word_t dv = 32'h00000008 | `OPC_DIV;
   localparam bus_word_t da = 32'h00000008 | `OPC_DADD;
   localparam bus_word_t ds = 32'h00000008 | `OPC_DSUB;
   localparam bus_word_t ac = 32'h00000008 | `OPC_ADDC;

   saturating_arith_unit #(.WORD_W(16)) dut_u (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .address               (address),
      .read                  (read),
      .write                 (write),
      .writedata             (writedata),
      .byteenable            (byteenable),
      .readdata              (readdata),
      .waitrequest           (waitrequest),
      .irq                   (irq),
      .instruction_out       (instruction_out),
      .carry_flag_device_bit (carry_flag_device_bit),
      .error_flag_device_bit (error_flag_device_bit)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input bus_word_t seen, input bus_word_t exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // The request stands until the rising edge at which waitrequest is seen
   // low; that edge commits a write and carries the read data.
   task automatic bus(input logic wr, input logic [5:0] a, input bus_word_t d);
      int i;
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         check("waitrequest", waitrequest, 32'h0);
         finish_test();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input bus_word_t d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [5:0] a, input bus_word_t exp, input string name);
      bus(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask

   task automatic chk_irq(input logic exp);
      repeat (2) @(negedge clk);
      check("irq", irq, exp);
   endtask

   // Loads operands, executes one command and checks result, flags and pins.
   task automatic run(input bus_word_t a, b, c, er, m, input logic eo, ec, ee);
      wr(`OFS_OPA, a);
      wr(`OFS_OPB, b);
      wr(`OFS_CMD, c);
      bus(1'b0, `OFS_RES, 32'h0);
      check("result", rd & m, er & m);
      rdc(`OFS_FLAGS, {29'h0, eo, ee, ec}, "flags");
      @(negedge clk);
      check("instruction_out", instruction_out, eo);
      check("carry_flag_device_bit", carry_flag_device_bit, ec);
      check("error_flag_device_bit", error_flag_device_bit, ee);
   endtask

   // ************************************************************
   // Stimulus
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hF;
      n_errors = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check("waitrequest", waitrequest, 32'h1);
      @(posedge clk);
      rst_n <= 1'b1;
      rdc(`OFS_FLAGS, 32'h0, "flags");
      rdc(`OFS_RES, 32'h0, "result");
      rdc(6'h20, 32'h0, "unmapped");
      wr(`OFS_IRQ_EN, 32'h1);
      run(32'h00000B4E, 32'h00000145, dv, 32'h01260008, al, 1, 0, 0);
      run(32'h00000B4E, 32'h00000000, dv, 32'h01260008, al, 0, 0, 1);
      rdc(`OFS_IRQ_STAT, 32'h1, "irq_status");
      chk_irq(1'b1);
      wr(`OFS_IRQ_EN, 32'h0);
      chk_irq(1'b0);
      wr(`OFS_IRQ_EN, 32'h1);
      chk_irq(1'b1);
      wr(`OFS_IRQ_CLR, 32'h1);
      chk_irq(1'b0);
      rdc(`OFS_IRQ_STAT, 32'h0, "irq_status");
      // The result register is read-only, so this write must leave no trace.
      wr(`OFS_RES, 32'hDEADBEEF);
      run(32'h0000FFF9, 32'h00000002, dv, 32'hFFFFFFFD, al, 1, 0, 1);
      run(32'h00000064, 32'h00000007, dv | k, 32'hFFFF000E, al, 1, 0, 1);
      run(32'h00008000, 32'h0000FFFF, dv, 32'h00008000, al, 1, 0, 1);
      run(32'h00000001, 32'h00000000, `OPC_DIV, 32'h00008000, al, 0, 0, 1);
      wr(`OFS_FLAGS, 32'h2);
      rdc(`OFS_FLAGS, 32'h0, "flags");
      run(32'h000493E0, 32'h000186A0, da, 32'h00061A80, al, 0, 0, 0);
      run(32'h7FFFFFF0, 32'h00000020, da, 32'h7FFFFFFF, al, 1, 0, 0);
      run(32'h80000000, 32'hFFFFFFFF, da, 32'h80000000, al, 1, 0, 0);
      run(32'h00181BE0, 32'h00013880, ds, 32'h0016E360, al, 0, 0, 0);
      run(32'h80000000, 32'h00000001, ds, 32'h80000000, al, 1, 0, 0);
      run(32'h7FFFFFFF, 32'hFFFFFFFF, ds, 32'h7FFFFFFF, al, 1, 0, 0);
      run(32'h00000001, 32'h00000001, `OPC_DADD, 32'h7FFFFFFF, al, 0, 0, 0);
      wr(`OFS_FLAGS, 32'h1);
      run(32'h0000614E, 32'h0000D432, ac, 32'h00003580, lo, 0, 1, 0);
      run(32'h000000BC, 32'h00000000, ac, 32'h000000BD, lo, 0, 0, 0);
      run(32'h00007FFF, 32'h00000001, ac, 32'h00008000, lo, 1, 0, 0);
      run(32'h0000FFFF, 32'h0000FFFF, ac, 32'h0000FFFE, lo, 0, 1, 0);
      run(32'h00000001, 32'h00000001, `OPC_ADDC, 32'h0000FFFE, lo, 0, 1, 0);
      run(32'h00007FFF, 32'h00000000, ac, 32'h00008000, lo, 1, 0, 0);
      run(32'h00008000, 32'h00008000, ac, 32'h00000000, lo, 1, 1, 0);
      rdc(`OFS_IRQ_STAT, 32'h6, "irq_status");
      rdc(`OFS_CMD, ac, "command");
      byteenable <= 4'h3;
      wr(`OFS_OPA, al);
      byteenable <= 4'hF;
      rdc(`OFS_OPA, 32'h0000FFFF, "operand_a");
      finish_test();
   end
endmodule

`default_nettype wire
